// file: rtl/pesp_packetizer.sv
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
// Notes on behaviour
// RL1: science mode streams flux and dose packet
// RL2: at most 56 bytes, once per interval
// RL3: interval selectable 5/10/20/30/60 seconds
// RL4: fixed packet byte order, sync last
// RL5: three bytes carry grouped proton bin sums
// RL6: status byte one holds threshold settings
// RL7: status byte two holds leakage alarms
// RL8: status nibbles, odd upper, even lower
// RL9: one byte carries eight warning flags
// RL10: upset pulses above threshold counted only
// RL11: leakage alarm raises processor warning output
// RL12: dosimeters alternate one second each
// RL13: processor drives the dosimeter input multiplexer
// RL14: dosimeter trigger gates 5 us 10 MHz sampling
// RL15: largest sample in window is peak
// RL16: gain range travels with each peak
// RL17: eight thresholds give each detector level
// RL18: triggers within 500 ns are coincidence
// RL19: coincidence and singles counts kept, readable
// RL20: events binned by front, back level
// RL21: counters snapshot, clear, saturate at boundary
// RL22: unused bytes zero, frame counter increments
module pesp_packetizer
  import pesp_pkg::*;
#(
  parameter int TICKS_PER_SEC = 40_000_000,
  parameter int ADC_W         = 8
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic [7:0]         paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [7:0]         front_threshold_hit,
  input  wire logic [7:0]         back_threshold_hit,
  input  wire logic               front_fast_trigger,
  input  wire logic               back_fast_trigger,
  input  wire logic               dosimeter_one_fast_trigger,
  input  wire logic               dosimeter_two_fast_trigger,
  input  wire logic               dosimeter_one_gain_range,
  input  wire logic               dosimeter_two_gain_range,
  input  wire logic [ADC_W-1:0]   dosimeter_adc_data,
  input  wire logic               upset_pulse,
  input  wire logic               front_leakage_alarm,
  input  wire logic               back_leakage_alarm,
  input  wire logic               dosimeter_one_leakage_alarm,
  input  wire logic               dosimeter_two_leakage_alarm,
  input  wire logic [4:0]         threshold_high,
  output logic                    dosimeter_select,
  output logic                    adc_gate,
  output logic                    leakage_warning,
  output logic                    tm_valid,
  output logic [7:0]              tm_data,
  output logic                    tm_last,
  input  wire logic               tm_ready
);
  localparam int PIN_W = 8 + 8 + 7 + ADC_W + 4 + 5;
  localparam int SEC_W = $clog2(TICKS_PER_SEC);
  localparam logic [SEC_W-1:0] SEC_LAST   = SEC_W'(TICKS_PER_SEC - 1);
  localparam logic [7:0]       GATE_LAST  = 8'(GATE_SAMPLES - 1);
  localparam logic [7:0]       DIV_LAST   = 8'(SAMPLE_DIV - 1);
  localparam logic [7:0]       COINC_LAST = 8'(COINC_CYC - 1);
  localparam logic [15:0]      GATE_SPAN  = 16'((GATE_SAMPLES - 1) * SAMPLE_DIV);
  localparam logic [5:0]       PKT_LAST   = 6'(PKT_BYTES - 1);

  initial begin
    if (ADC_W < 1 || ADC_W > 12) $error("ADC_W must be 1..12");
    if (TICKS_PER_SEC < 2) $error("TICKS_PER_SEC must be at least 2");
  end

  function automatic logic [3:0] level_of(input logic [7:0] hits); // RL17
    logic [3:0] lv;
    lv = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (hits[i]) lv = 4'(i + 1);
    end
    return lv;
  endfunction

  function automatic logic [6:0] bin_index(input logic [3:0] m, input logic [3:0] n);
    return 7'(m * NUM_LEVELS + n);
  endfunction

  function automatic logic [7:0] sat8(input logic [11:0] x);
    return (x > 12'h0FF) ? 8'hFF : x[7:0];
  endfunction

  // ---------------- pin synchronisers
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic [4:0]       trig_prev;
  wire  [PIN_W-1:0] pin_raw = {front_threshold_hit, back_threshold_hit, front_fast_trigger, back_fast_trigger,
                               dosimeter_one_fast_trigger, dosimeter_two_fast_trigger, dosimeter_one_gain_range,
                               dosimeter_two_gain_range, upset_pulse, dosimeter_adc_data, front_leakage_alarm,
                               back_leakage_alarm, dosimeter_one_leakage_alarm, dosimeter_two_leakage_alarm,
                               threshold_high};
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_meta  <= '0;
      pin_sync  <= '0;
      trig_prev <= 5'h00;
    end else begin
      pin_meta  <= pin_raw;
      pin_sync  <= pin_meta;
      // one history bit per trigger so each edge detector sees its own pin
      trig_prev <= {pin_sync[PIN_W-17 -: 4], pin_sync[PIN_W-23]};
    end
  end
  wire [7:0]       f_hits   = pin_sync[PIN_W-1 -: 8];
  wire [7:0]       b_hits   = pin_sync[PIN_W-9 -: 8];
  wire             f_trig   = pin_sync[PIN_W-17];
  wire             b_trig   = pin_sync[PIN_W-18];
  wire             d1_trig  = pin_sync[PIN_W-19];
  wire             d2_trig  = pin_sync[PIN_W-20];
  wire             d1_gain  = pin_sync[PIN_W-21];
  wire             d2_gain  = pin_sync[PIN_W-22];
  wire             upset_s  = pin_sync[PIN_W-23];
  wire [ADC_W-1:0] adc_s    = pin_sync[9 +: ADC_W];
  wire [3:0]       leak_s   = pin_sync[8:5];
  wire [4:0]       thr_s    = pin_sync[4:0];
  wire             f_rise   = f_trig & ~trig_prev[4];
  wire             b_rise   = b_trig & ~trig_prev[3];
  wire             d_rise   = dosimeter_select ? (d2_trig & ~trig_prev[1]) : (d1_trig & ~trig_prev[2]);
  wire             up_rise  = upset_s & ~trig_prev[0];
  wire             dos_gain = dosimeter_select ? d2_gain : d1_gain;

  // ---------------- apb registers
  logic [3:0]  ctrl;
  logic [31:0] dose_a;
  logic [31:0] dose_b;
  logic [23:0] sr_nib;
  logic [15:0] warn_proc;
  logic        addr_bad;
  wire  hit_ctrl = (paddr == ADDR_CTRL);
  wire  hit_da   = (paddr == ADDR_DOSE_A);
  wire  hit_db   = (paddr == ADDR_DOSE_B);
  wire  hit_sr   = (paddr == ADDR_SR_NIB);
  wire  hit_wp   = (paddr == ADDR_WARN_PROC);
  wire  hit_ro   = (paddr == ADDR_STATUS) | (paddr == ADDR_TEL_CNT) | (paddr == ADDR_PEAK);
  wire  hit_any  = hit_ctrl | hit_da | hit_db | hit_sr | hit_wp | hit_ro;
  wire  setup    = psel & ~penable;
  wire  wr_en    = psel & penable & pwrite & ~addr_bad;
  wire  science_en = ctrl[CTRL_EN_BIT];
  wire  [2:0] int_sel = ctrl[CTRL_SEL_LSB +: 3];
  wire  [5:0] int_secs = (int_sel < 3'(NUM_INTERVALS)) ? INTERVAL_SECS[int_sel] : INTERVAL_SECS[NUM_INTERVALS-1]; // RL3

  // ---------------- status produced by the block
  logic [15:0] frame_cnt;
  logic [15:0] coinc_cnt, single_cnt, coinc_snap, single_snap;
  logic [ADC_W-1:0] peak_val;
  logic        peak_gain, peak_id;
  logic [15:0] peak_count;
  pesp_tx_state_t tx_state;
  wire  [31:0] rd_mux =
      hit_ctrl ? {28'h0, ctrl} :
      hit_da   ? dose_a :
      hit_db   ? dose_b :
      hit_sr   ? {8'h0, sr_nib} :
      hit_wp   ? {16'h0, warn_proc} :
      (paddr == ADDR_STATUS)  ? {11'h0, leak_s, tx_state == PESP_TX_SEND, frame_cnt} :
      (paddr == ADDR_TEL_CNT) ? {single_snap, coinc_snap} : // RL19
      (paddr == ADDR_PEAK)    ? {peak_count, 2'h0, peak_id, peak_gain, 12'(peak_val)} : 32'h0;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & addr_bad;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl      <= CTRL_RESET;
      dose_a    <= 32'h0;
      dose_b    <= 32'h0;
      sr_nib    <= 24'h0;
      warn_proc <= 16'h0;
      prdata    <= 32'h0;
      addr_bad  <= 1'b0;
    end else begin
      if (setup) begin
        prdata   <= pwrite ? 32'h0 : rd_mux;
        addr_bad <= ~hit_any | (pwrite & hit_ro);
      end
      if (wr_en && hit_ctrl) ctrl <= pwdata[3:0];
      if (wr_en && hit_da) dose_a <= pwdata;
      if (wr_en && hit_db) dose_b <= pwdata;
      if (wr_en && hit_sr) sr_nib <= pwdata[23:0];
      if (wr_en && hit_wp) warn_proc <= pwdata[15:0];
    end
  end

  // ---------------- second tick, interval boundary, dosimeter alternation
  logic [SEC_W-1:0] sec_cnt;
  logic [5:0]       int_cnt;
  wire  sec_tick = (sec_cnt == SEC_LAST);
  wire  boundary = sec_tick & (int_cnt >= int_secs - 6'h01);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sec_cnt          <= '0;
      int_cnt          <= 6'h00;
      dosimeter_select <= 1'b0;
      leakage_warning  <= 1'b0;
    end else begin
      sec_cnt <= sec_tick ? '0 : sec_cnt + 1'b1;
      if (sec_tick) int_cnt <= boundary ? 6'h00 : int_cnt + 6'h01;
      if (sec_tick) dosimeter_select <= ~dosimeter_select; // RL12
      leakage_warning <= |leak_s; // RL11
    end
  end

  // ---------------- dosimeter peak capture
  pesp_peak_state_t pk_state;
  logic [7:0]       pk_div, pk_nsamp;
  logic [ADC_W-1:0] pk_max;
  logic             pk_gain_cap, pk_id_cap;
  logic [15:0]      pk_cyc;
  wire  sample_stb = (pk_state == PESP_PK_GATE) && (pk_div == 8'h00);
  wire  [ADC_W-1:0] next_max = (adc_s > pk_max) ? adc_s : pk_max; // RL15
  wire  pk_done = sample_stb && (pk_nsamp == GATE_LAST);
  assign adc_gate = (pk_state == PESP_PK_GATE); // RL14
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pk_state <= PESP_PK_IDLE;
      pk_div <= 8'h00;
      pk_nsamp <= 8'h00;
      pk_max <= '0;
      pk_gain_cap <= 1'b0;
      pk_id_cap <= 1'b0;
      pk_cyc <= 16'h0;
      peak_val <= '0;
      peak_gain <= 1'b0;
      peak_id <= 1'b0;
      peak_count <= 16'h0;
    end else begin
      unique case (pk_state)
        PESP_PK_IDLE: begin
          if (d_rise) begin
            pk_state <= PESP_PK_GATE;
            pk_div <= 8'h00;
            pk_nsamp <= 8'h00;
            pk_max <= '0;
            pk_cyc <= 16'h0;
            pk_gain_cap <= dos_gain; // RL16
            pk_id_cap <= dosimeter_select;
          end
        end
        PESP_PK_GATE: begin
          pk_div <= (pk_div == DIV_LAST) ? 8'h00 : pk_div + 8'h01; // RL14
          pk_cyc <= pk_cyc + 16'h1;
          if (sample_stb) begin
            pk_max <= next_max;
            pk_nsamp <= pk_nsamp + 8'h01;
          end
          if (pk_done) begin
            pk_state <= PESP_PK_IDLE;
            peak_val <= next_max; // RL15
            peak_gain <= pk_gain_cap; // RL16
            peak_id <= pk_id_cap;
            peak_count <= peak_count + 16'h1;
          end
        end
      endcase
    end
  end

  // ---------------- telescope coincidence and binning
  pesp_coinc_state_t co_state;
  logic [7:0] co_cnt, f_acc, b_acc;
  logic       got_f, got_b;
  wire  ev_valid = (co_state == PESP_CO_OPEN) && (co_cnt == COINC_LAST);
  wire  ev_coinc = got_f & got_b; // RL18
  wire  [3:0] ev_m = got_f ? level_of(f_acc) : 4'h0; // RL20
  wire  [3:0] ev_n = got_b ? level_of(b_acc) : 4'h0;
  wire  [6:0] ev_bin = bin_index(ev_m, ev_n);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      co_state <= PESP_CO_IDLE;
      co_cnt <= 8'h00;
      f_acc <= 8'h00;
      b_acc <= 8'h00;
      got_f <= 1'b0;
      got_b <= 1'b0;
    end else begin
      unique case (co_state)
        PESP_CO_IDLE: begin
          if (f_rise || b_rise) begin
            co_state <= PESP_CO_OPEN;
            co_cnt <= 8'h00;
            got_f <= f_rise;
            got_b <= b_rise;
            f_acc <= f_hits;
            b_acc <= b_hits;
          end
        end
        PESP_CO_OPEN: begin
          co_cnt <= co_cnt + 8'h01;
          got_f <= got_f | f_rise; // RL18
          got_b <= got_b | b_rise;
          f_acc <= f_acc | f_hits; // RL17
          b_acc <= b_acc | b_hits;
          if (ev_valid) co_state <= PESP_CO_IDLE;
        end
      endcase
    end
  end

  // ---------------- saturating counters, snapshot and clear at the boundary
  logic [7:0] bin_cnt [NUM_BINS];
  logic [7:0] snap [NUM_BINS];
  logic [7:0] upset_cnt, upset_snap;
  wire  up_ev = up_rise;
  wire  co_ev = ev_valid & ev_coinc;
  wire  si_ev = ev_valid & ~ev_coinc;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_BINS; i++) begin
        bin_cnt[i] <= 8'h00;
        snap[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < NUM_BINS; i++) begin
        if (boundary) begin
          snap[i] <= bin_cnt[i]; // RL21
          bin_cnt[i] <= (ev_valid && ev_bin == 7'(i)) ? 8'h01 : 8'h00;
        end else if (ev_valid && ev_bin == 7'(i) && bin_cnt[i] != 8'hFF) begin
          bin_cnt[i] <= bin_cnt[i] + 8'h01; // RL20
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      upset_cnt <= 8'h00;
      upset_snap <= 8'h00;
      coinc_cnt <= 16'h0;
      single_cnt <= 16'h0;
      coinc_snap <= 16'h0;
      single_snap <= 16'h0;
    end else if (boundary) begin
      upset_snap <= upset_cnt;
      coinc_snap <= coinc_cnt;
      single_snap <= single_cnt;
      upset_cnt <= {7'h00, up_ev}; // RL21
      coinc_cnt <= {15'h0, co_ev};
      single_cnt <= {15'h0, si_ev};
    end else begin
      if (up_ev && upset_cnt != 8'hFF) upset_cnt <= upset_cnt + 8'h01; // RL10
      if (co_ev && coinc_cnt != 16'hFFFF) coinc_cnt <= coinc_cnt + 16'h1; // RL19
      if (si_ev && single_cnt != 16'hFFFF) single_cnt <= single_cnt + 16'h1;
    end
  end

  // ---------------- packet assembly
  function automatic logic [11:0] bn(input int m, input int n);
    return {4'h0, snap[m * NUM_LEVELS + n]};
  endfunction
  wire [7:0] sum_x1 = sat8(bn(6, 1) + bn(7, 1) + bn(8, 1));
  wire [7:0] sum_x2 = sat8(bn(6, 2) + bn(7, 2) + bn(8, 2));
  wire [7:0] sum_x3 = sat8(bn(6, 3) + bn(7, 3) + bn(8, 3));
  wire [7:0] sum_1  = sat8(bn(6, 4) + bn(7, 4) + bn(8, 4) + bn(6, 5) + bn(7, 5) + bn(8, 5)); // RL5
  wire [7:0] sum_2  = sat8(bn(6, 6) + bn(7, 6) + bn(8, 6) + bn(6, 7) + bn(7, 7) + bn(6, 8) + bn(7, 8)); // RL5
  wire [7:0] sum_5a = sat8(bn(5, 4) + bn(5, 5) + bn(5, 6));
  wire [7:0] sum_5b = sat8(bn(5, 7) + bn(5, 8));
  wire [7:0] sum_3  = sat8(bn(0, 4) + bn(0, 5) + bn(0, 6) + bn(0, 7) + bn(0, 8)); // RL5
  wire [63:0] dose_bytes = {dose_a, dose_b};

  logic [5:0] tx_idx;
  wire  start     = boundary & science_en & (tx_state == PESP_TX_IDLE); // RL1 RL2
  wire  accept    = tm_valid & tm_ready;
  wire  [5:0] sel = (tx_state == PESP_TX_IDLE) ? 6'h00 : tx_idx + 6'h01;
  logic [7:0] next_byte;
  always_comb begin
    next_byte = 8'h00; // RL22
    if (sel < PB_UPSET) next_byte = dose_bytes[6'(7 - 3'(sel)) * 8 +: 8]; // RL4
    else if (BIN_OF[sel] != BIN_NONE) next_byte = snap[BIN_OF[sel]];
    case (sel)
      PB_UPSET:    next_byte = upset_snap; // RL10
      PB_S_X1:     next_byte = sum_x1;
      PB_S_X2:     next_byte = sum_x2;
      PB_S_X3:     next_byte = sum_x3;
      PB_SUM1:     next_byte = sum_1;
      PB_SUM2:     next_byte = sum_2;
      PB_S_5A:     next_byte = sum_5a;
      PB_S_5B:     next_byte = sum_5b;
      PB_SUM3:     next_byte = sum_3;
      PB_STAT1:    next_byte = {thr_s, 3'h0}; // RL6
      PB_STAT2:    next_byte = {leak_s, 4'h0}; // RL7
      PB_SR12:     next_byte = sr_nib[23:16]; // RL8
      PB_SR34:     next_byte = sr_nib[15:8];
      PB_SR56:     next_byte = sr_nib[7:0];
      PB_WARN:     next_byte = warn_proc[7:0]; // RL9
      PB_PROC:     next_byte = warn_proc[15:8];
      PB_FRAME_HI: next_byte = frame_cnt[15:8];
      PB_FRAME_LO: next_byte = frame_cnt[7:0];
      PB_SYNC1:    next_byte = SYNC_BYTE1;
      PB_SYNC2:    next_byte = SYNC_BYTE2;
      default:     ;
    endcase
  end
  assign tm_last = tm_valid & (tx_idx == PKT_LAST); // RL2

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_state <= PESP_TX_IDLE;
      tx_idx <= 6'h00;
      tm_valid <= 1'b0;
      tm_data <= 8'h00;
      frame_cnt <= 16'h0;
    end else begin
      unique case (tx_state)
        PESP_TX_IDLE: begin
          if (start) begin
            tx_state <= PESP_TX_SEND;
            tx_idx <= 6'h00;
            tm_valid <= 1'b1;
            tm_data <= next_byte;
          end
        end
        PESP_TX_SEND: begin
          if (accept && tx_idx == PKT_LAST) begin
            tx_state <= PESP_TX_IDLE;
            tm_valid <= 1'b0;
            frame_cnt <= frame_cnt + 16'h1; // RL22
          end else if (accept) begin
            tx_idx <= sel;
            tm_data <= next_byte;
          end
        end
      endcase
    end
  end

  // ---------------- checks
  a_pkt_length: assert property (@(posedge clk) disable iff (!resetn) // RL2
    accept && tm_last |=> !tm_valid && frame_cnt == $past(frame_cnt) + 16'h1) else $error("packet end wrong");
  a_sync_bytes: assert property (@(posedge clk) disable iff (!resetn) // RL4
    tm_valid && tx_idx == PKT_LAST |-> tm_data == SYNC_BYTE2) else $error("sync byte wrong");
  a_data_hold: assert property (@(posedge clk) disable iff (!resetn) // RL1
    tm_valid && !tm_ready |=> tm_valid && $stable(tm_data) && $stable(tx_idx)) else $error("stream dropped");
  a_gate_len: assert property (@(posedge clk) disable iff (!resetn) // RL14
    pk_done |-> pk_cyc == GATE_SPAN) else $error("gate length wrong");
  a_peak_max: assert property (@(posedge clk) disable iff (!resetn) // RL15
    pk_done |=> peak_val >= $past(adc_s) && peak_val >= $past(pk_max)) else $error("peak not max");
  a_coinc_window: assert property (@(posedge clk) disable iff (!resetn) // RL18
    co_state == PESP_CO_OPEN && co_cnt < COINC_LAST && got_f && b_rise
    |-> ##[1:20] (ev_valid && ev_coinc)) else $error("coincidence missed");
  a_upset_count: assert property (@(posedge clk) disable iff (!resetn) // RL10
    up_ev && !boundary && upset_cnt < 8'hFF |=> upset_cnt == $past(upset_cnt) + 8'h01) else $error("upset lost");
  a_leak_warn: assert property (@(posedge clk) disable iff (!resetn) // RL11
    |leak_s |=> leakage_warning) else $error("leak warning absent");
  a_dose_alt: assert property (@(posedge clk) disable iff (!resetn) // RL12
    sec_tick |=> dosimeter_select != $past(dosimeter_select)) else $error("dosimeter not switched");
  c_packet_sent: cover property (@(posedge clk) disable iff (!resetn) accept && tm_last);
  c_coinc_event: cover property (@(posedge clk) disable iff (!resetn) co_ev);
  c_peak_done: cover property (@(posedge clk) disable iff (!resetn) pk_done);
endmodule // pesp_packetizer

// file: rtl/pesp_pkg.sv
package pesp_pkg;
  // timing figures as printed, cycle counts derived from the clock rate
  localparam int CLK_HZ      = 40_000_000;
  localparam int SAMPLE_HZ   = 10_000_000;
  localparam int GATE_NS     = 5000;
  localparam int COINC_NS    = 500;
  localparam int SAMPLE_DIV  = CLK_HZ / SAMPLE_HZ;
  localparam int GATE_SAMPLES = (GATE_NS * (SAMPLE_HZ / 1_000_000)) / 1000;
  // longest time: rounds down
  localparam int COINC_CYC   = (COINC_NS * (CLK_HZ / 1_000_000)) / 1000;

  localparam int PKT_BYTES   = 56;
  localparam int NUM_LEVELS  = 9;
  localparam int NUM_BINS    = NUM_LEVELS * NUM_LEVELS;
  localparam int NUM_INTERVALS = 5;

  localparam logic [7:0] SYNC_BYTE1 = 8'hEB;
  localparam logic [7:0] SYNC_BYTE2 = 8'h90;

  // apb byte addresses
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_DOSE_A    = 8'h04;
  localparam logic [7:0] ADDR_DOSE_B    = 8'h08;
  localparam logic [7:0] ADDR_SR_NIB    = 8'h0C;
  localparam logic [7:0] ADDR_WARN_PROC = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;
  localparam logic [7:0] ADDR_TEL_CNT   = 8'h18;
  localparam logic [7:0] ADDR_PEAK      = 8'h1C;

  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [5:0] INTERVAL_SECS [NUM_INTERVALS] = '{6'h05, 6'h0A, 6'h14, 6'h1E, 6'h3C};

  // packet byte positions, zero based
  localparam logic [5:0] PB_UPSET    = 6'h08;
  localparam logic [5:0] PB_S_X1     = 6'h1B;
  localparam logic [5:0] PB_S_X2     = 6'h1C;
  localparam logic [5:0] PB_S_X3     = 6'h1D;
  localparam logic [5:0] PB_SUM1     = 6'h1E;
  localparam logic [5:0] PB_SUM2     = 6'h1F;
  localparam logic [5:0] PB_S_5A     = 6'h20;
  localparam logic [5:0] PB_S_5B     = 6'h21;
  localparam logic [5:0] PB_SUM3     = 6'h28;
  localparam logic [5:0] PB_STAT1    = 6'h29;
  localparam logic [5:0] PB_STAT2    = 6'h2A;
  localparam logic [5:0] PB_SR12     = 6'h2B;
  localparam logic [5:0] PB_SR34     = 6'h2C;
  localparam logic [5:0] PB_SR56     = 6'h2D;
  localparam logic [5:0] PB_WARN     = 6'h2E;
  localparam logic [5:0] PB_PROC     = 6'h32;
  localparam logic [5:0] PB_FRAME_HI = 6'h34;
  localparam logic [5:0] PB_FRAME_LO = 6'h35;
  localparam logic [5:0] PB_SYNC1    = 6'h36;
  localparam logic [5:0] PB_SYNC2    = 6'h37;

  // single energy-bin bytes: value is front_level*9 + back_level
  localparam logic [6:0] BIN_NONE = 7'h7F;
  localparam logic [6:0] BIN_OF [PKT_BYTES] = '{
    7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F,
    7'h09, 7'h12, 7'h1B, 7'h24, 7'h0A, 7'h13, 7'h1C, 7'h25, 7'h0B, 7'h14, 7'h1D, 7'h0C, 7'h15, 7'h1E,
    7'h2D, 7'h36, 7'h3F, 7'h48,
    7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F,
    7'h28, 7'h29, 7'h2A, 7'h2B, 7'h2C, 7'h1F,
    7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F,
    7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F};

  typedef enum logic {PESP_PK_IDLE = 1'b0, PESP_PK_GATE = 1'b1} pesp_peak_state_t;
  typedef enum logic {PESP_CO_IDLE = 1'b0, PESP_CO_OPEN = 1'b1} pesp_coinc_state_t;
  typedef enum logic {PESP_TX_IDLE = 1'b0, PESP_TX_SEND = 1'b1} pesp_tx_state_t;
endpackage

// file: verif/pesp_tm_sink.sv
`timescale 1ns/100ps
module pesp_tm_sink (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       tm_valid,
  input  wire logic [7:0] tm_data,
  input  wire logic       tm_last,
  input  wire logic       slow,
  output logic            tm_ready
);
  logic [7:0] pkt [56];
  logic [1:0] ph      = 2'h0;
  int         n       = 0;
  int         done    = 0;
  int         last_at = -1;
  initial tm_ready = 1'b0;
  // slow mode refuses one cycle in four so the offer must hold
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    tm_ready <= resetn && !(slow && ph == 2'h0);
    if (tm_valid && tm_ready) begin
      if (n < 56) pkt[n] <= tm_data;
      n <= tm_last ? 0 : n + 1;
      if (tm_last) begin
        last_at <= n;
        done <= done + 1;
      end
    end
  end
endmodule // pesp_tm_sink

// file: verif/tb_particle_event_science_packetizer.sv
`timescale 1ns/100ps
module tb_particle_event_science_packetizer;
  import pesp_pkg::*;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, upset = 0, ftrig = 0, ready;
  logic [7:0] paddr = 8'h00, fhit = 8'h00, tm_data;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, tm_valid, tm_last, dsel, gate, lwarn;
  logic btrig = 0, d1trig = 0, d1gain = 0, slow = 1;
  logic [7:0] bhit = 8'h00, adc = 8'h00;
  logic [4:0] thr = 5'h16;
  int miscompares = 0, checked = 0, cyc = 0, t1;
  always #12.5 clk = ~clk;
  pesp_packetizer #(.TICKS_PER_SEC(16)) dut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .front_threshold_hit(fhit), .back_threshold_hit(bhit), .front_fast_trigger(ftrig),
    .back_fast_trigger(btrig), .dosimeter_one_fast_trigger(d1trig), .dosimeter_two_fast_trigger(1'b0),
    .dosimeter_one_gain_range(d1gain), .dosimeter_two_gain_range(1'b0), .dosimeter_adc_data(adc),
    .upset_pulse(upset), .front_leakage_alarm(resetn), .back_leakage_alarm(1'b0),
    .dosimeter_one_leakage_alarm(1'b0), .dosimeter_two_leakage_alarm(1'b0), .threshold_high(thr),
    .dosimeter_select(dsel), .adc_gate(gate), .leakage_warning(lwarn), .tm_valid(tm_valid),
    .tm_data(tm_data), .tm_last(tm_last), .tm_ready(ready));
  pesp_tm_sink sink (.clk(clk), .resetn(resetn), .tm_valid(tm_valid), .tm_data(tm_data),
    .tm_last(tm_last), .slow(slow), .tm_ready(ready));
  task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
    checked++;
    if (g !== x) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(logic [7:0] a, logic w, logic [31:0] d);
    psel <= 1; paddr <= a; pwrite <= w; pwdata <= d; penable <= 0;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task automatic wait_pkt();
    int d0 = sink.done;
    while (sink.done == d0) @(posedge clk);
  endtask
  task automatic t_regs();
    apb(8'h20, 0, 0); chk("unmapped err", 1, e);
    apb(ADDR_STATUS, 1, 0); chk("ro write err", 1, e);
    apb(ADDR_CTRL, 1, 32'h3); apb(ADDR_CTRL, 0, 0); chk("ctrl", 32'h3, r & 32'hF);
  endtask
  task automatic t_events();
    repeat (3) begin
      upset <= 1; repeat (2) @(posedge clk);
      upset <= 0; repeat (2) @(posedge clk);
    end
    fhit <= 8'h01; ftrig <= 1; repeat (30) @(posedge clk);
    fhit <= 8'h00; ftrig <= 0; repeat (2) @(posedge clk);
    fhit <= 8'h01; bhit <= 8'h03; ftrig <= 1; btrig <= 1; repeat (25) @(posedge clk);
    fhit <= 8'h00; bhit <= 8'h00; ftrig <= 0; btrig <= 0;
  endtask
  task automatic t_peak();
    while (dsel !== 1'b1) @(posedge clk);
    while (dsel !== 1'b0) @(posedge clk);
    adc <= 8'h5A; d1gain <= 1; d1trig <= 1;
    repeat (5) @(posedge clk);
    chk("adc gate", 1, gate);
    d1trig <= 0;
    repeat (200) @(posedge clk);
    chk("adc gate end", 0, gate);
    apb(ADDR_PEAK, 0, 0); chk("peak", 32'h0001105A, r);
  endtask
  task automatic t_packet();
    wait_pkt(); t1 = cyc;
    t_events();
    chk("leak warning", 1, lwarn);
    wait_pkt();
    chk("interval", 160, cyc - t1);
    chk("last index", 55, sink.last_at);
    chk("upset", 3, sink.pkt[PB_UPSET]);
    chk("bin 1 0", 1, sink.pkt[9]);
    chk("bin 1 2", 1, sink.pkt[17]);
    chk("status1", 8'hB0, sink.pkt[PB_STAT1] & 8'hF8);
    chk("status2", 8'h80, sink.pkt[PB_STAT2] & 8'hF0);
    chk("frame", 16'h0001, {sink.pkt[PB_FRAME_HI], sink.pkt[PB_FRAME_LO]});
    chk("sync", {SYNC_BYTE1, SYNC_BYTE2}, {sink.pkt[PB_SYNC1], sink.pkt[PB_SYNC2]});
    for (int i = 47; i < 50; i++) chk("unused", 0, sink.pkt[i]);
    apb(ADDR_TEL_CNT, 0, 0); chk("singles", 32'h00010001, r);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    t_regs();
    t_packet();
    t_peak();
    tally_and_finish();
  end
endmodule // tb_particle_event_science_packetizer
